//--- src/itfm_pkg.sv
package itfm_pkg;

  // ************************************************************
  // Terminal count and option codes
  // ************************************************************
  localparam int NUM_TERM = 5;
  localparam logic [7:0] OPT_RUN_FWD = 8'h00;
  localparam logic [7:0] OPT_RUN_REV = 8'h01;
  localparam logic [7:0] OPT_SPEED_BIT0 = 8'h02;
  localparam logic [7:0] OPT_SPEED_BIT1 = 8'h03;
  localparam logic [7:0] OPT_SPEED_BIT2 = 8'h04;
  localparam logic [7:0] OPT_SPEED_BIT3 = 8'h05;
  localparam logic [7:0] OPT_JOG = 8'h06;
  localparam logic [7:0] OPT_DC_BRAKE = 8'h07;
  localparam logic [7:0] OPT_MOTOR2 = 8'h08;
  localparam logic [7:0] OPT_RAMP2 = 8'h09;
  localparam logic [7:0] OPT_COAST = 8'h0b;
  localparam logic [7:0] OPT_EXT_TRIP = 8'h0c;
  localparam logic [7:0] OPT_RESTART_BLOCK = 8'h0d;
  localparam logic [7:0] OPT_ANALOG_KIND = 8'h10;
  localparam logic [7:0] OPT_FAULT_RESET = 8'h12;
  localparam logic [7:0] OPT_THERMISTOR = 8'h13;

  // ************************************************************
  // Polarity codes, trip codes and restart modes
  // ************************************************************
  localparam logic [7:0] POL_NORMALLY_OPEN = 8'h00;
  localparam logic [7:0] POL_NORMALLY_CLOSED = 8'h01;
  localparam logic [7:0] TRIP_CODE_EXTERNAL = 8'h0c;
  localparam logic [7:0] TRIP_CODE_NONE = 8'h00;
  localparam logic [7:0] RESTART_FROM_ZERO = 8'h00;
  localparam logic [7:0] RESTART_FROM_SPEED = 8'h01;

  // ************************************************************
  // Reset values per variant, terminal 1 in the lowest byte
  // ************************************************************
  localparam logic [4:0][7:0] EU_FUNC_RST = {8'h12, 8'h03, 8'h02, 8'h01, 8'h00};
  localparam logic [4:0][7:0] US_FUNC_RST = {8'h09, 8'h0d, 8'h10, 8'h01, 8'h00};
  localparam logic [4:0][7:0] EU_POL_RST = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [4:0][7:0] US_POL_RST = {8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RESTART_MODE_RST = 8'h00;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_FUNC_BASE = 8'h00;
  localparam logic [7:0] OFS_POL_BASE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_CONTROL = 8'h44;
  localparam logic [7:0] OFS_TRIP = 8'h48;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ST_RAW_LSB = 0;
  localparam int ST_ACTIVE_LSB = 8;
  localparam int ST_RUN_BIT = 16;
  localparam int ST_SPEED_LSB = 20;
  localparam int TRIP_LATCH_BIT = 0;
  localparam int TRIP_CLEAR_BIT = 0;
  localparam int TRIP_CODE_LSB = 8;

endpackage : itfm_pkg

//--- src/itfm_top.sv
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module itfm_top
  import itfm_pkg::*;
#(
  parameter bit US_VARIANT = 1'b0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [itfm_pkg::NUM_TERM-1:0] terminalPin,
  input wire logic [itfm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic runForwardCmd,
  output logic runReverseCmd,
  output logic [3:0] speedCode,
  output logic jogCmd,
  output logic extDcBrakeCmd,
  output logic secondMotorSelect,
  output logic secondRampSelect,
  output logic coastStopCmd,
  output logic runMode,
  output logic tripLatched,
  output logic [7:0] tripErrorCode,
  output logic faultResetCmd,
  output logic motorOutputOff,
  output logic powerupResetReq,
  output logic thermistorProtectInput,
  output logic restartFromZero,
  output logic restartFromSpeed
);
  import itfm_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] termAddr(input logic [7:0] base, input int idx);
    logic [7:0] step;
    step = {idx[5:0], 2'b00};
    termAddr = base + step;
  endfunction : termAddr

  function automatic logic anyActive(input logic [4:0] act, input logic [4:0][7:0] sel,
                                     input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (act[i] && sel[i] == code) begin
        hit = 1'b1;
      end
    end
    anyActive = hit;
  endfunction : anyActive

  localparam logic [4:0][7:0] FUNC_RST = US_VARIANT ? US_FUNC_RST : EU_FUNC_RST;
  localparam logic [4:0][7:0] POL_RST = US_VARIANT ? US_POL_RST : EU_POL_RST;

  // ************************************************************
  // Register and bus state
  // ************************************************************
  logic [4:0][7:0] funcSel_ff;
  logic [4:0][7:0] nxt_funcSel;
  logic [4:0][7:0] polSel_ff;
  logic [4:0][7:0] nxt_polSel;
  logic [7:0] restartMode_ff;
  logic [7:0] nxt_restartMode;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] readData_ff;
  logic [31:0] nxt_readData;
  logic tripClearReq;
  logic acc;
  logic wrAcc;

  // ************************************************************
  // Terminal and function state
  // ************************************************************
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] active;
  logic [4:0] invert;
  logic fwdNow;
  logic revNow;
  logic [3:0] speedNow;
  logic jogNow;
  logic coastNow;
  logic extTripNow;
  logic resetNow;
  logic extTripPrev_ff;
  logic nxt_extTripPrev;
  logic coastPrev_ff;
  logic nxt_coastPrev;
  logic [14:0] cmd_ff;
  logic [14:0] nxt_cmd;
  logic trip_ff;
  logic nxt_trip;
  logic [7:0] tripCode_ff;
  logic [7:0] nxt_tripCode;
  logic restartZero_ff;
  logic nxt_restartZero;
  logic restartSpeed_ff;
  logic nxt_restartSpeed;

  // ************************************************************
  // Terminal conditioning
  // ************************************************************
  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      invert[i] = polSel_ff[i][0] && funcSel_ff[i] != OPT_FAULT_RESET;
    end
    active = sync2_ff ^ invert;
    if (funcSel_ff[4] == OPT_THERMISTOR) begin
      active[4] = 1'b0;
    end
    fwdNow = anyActive(active, funcSel_ff, OPT_RUN_FWD);
    revNow = anyActive(active, funcSel_ff, OPT_RUN_REV);
    speedNow[0] = anyActive(active, funcSel_ff, OPT_SPEED_BIT0);
    speedNow[1] = anyActive(active, funcSel_ff, OPT_SPEED_BIT1);
    speedNow[2] = anyActive(active, funcSel_ff, OPT_SPEED_BIT2);
    speedNow[3] = anyActive(active, funcSel_ff, OPT_SPEED_BIT3);
    jogNow = anyActive(active, funcSel_ff, OPT_JOG);
    coastNow = anyActive(active, funcSel_ff, OPT_COAST);
    extTripNow = anyActive(active, funcSel_ff, OPT_EXT_TRIP);
    resetNow = anyActive(active, funcSel_ff, OPT_FAULT_RESET);
  end

  // ************************************************************
  // Input synchroniser
  // ************************************************************
  // Two stages keep a metastable pin level away from the routing logic.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= terminalPin;
      sync2_ff <= sync1_ff;
    end
  end

  // ************************************************************
  // Function outputs
  // ************************************************************
  // Every command is registered so that all outputs change on one edge together.
  always_comb begin
    nxt_cmd = '0;
    nxt_cmd[0] = fwdNow;
    nxt_cmd[1] = revNow;
    nxt_cmd[5:2] = speedNow;
    nxt_cmd[6] = jogNow;
    nxt_cmd[7] = anyActive(active, funcSel_ff, OPT_DC_BRAKE);
    nxt_cmd[8] = anyActive(active, funcSel_ff, OPT_MOTOR2);
    nxt_cmd[9] = anyActive(active, funcSel_ff, OPT_RAMP2);
    nxt_cmd[10] = coastNow;
    nxt_cmd[11] = fwdNow || revNow || jogNow;
    nxt_cmd[12] = resetNow;
    nxt_cmd[13] = funcSel_ff[4] == OPT_THERMISTOR;
    nxt_cmd[14] = coastNow || resetNow || nxt_trip;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  // ************************************************************
  // External trip latch
  // ************************************************************
  // An edge and a clear in one cycle leave the trip set, so no event is lost.
  always_comb begin
    nxt_extTripPrev = extTripNow;
    nxt_trip = trip_ff;
    nxt_tripCode = tripCode_ff;
    if (resetNow || tripClearReq) begin
      nxt_trip = 1'b0;
      nxt_tripCode = TRIP_CODE_NONE;
    end
    if (extTripNow && !extTripPrev_ff) begin
      nxt_trip = 1'b1;
      nxt_tripCode = TRIP_CODE_EXTERNAL;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      extTripPrev_ff <= 1'b0;
      trip_ff <= 1'b0;
      tripCode_ff <= TRIP_CODE_NONE;
    end else begin
      extTripPrev_ff <= nxt_extTripPrev;
      trip_ff <= nxt_trip;
      tripCode_ff <= nxt_tripCode;
    end
  end

  // ************************************************************
  // Coast restart pulses
  // ************************************************************
  // The pulse lasts one cycle, on the edge that releases the coast stop.
  always_comb begin
    nxt_coastPrev = coastNow;
    nxt_restartZero = 1'b0;
    nxt_restartSpeed = 1'b0;
    if (coastPrev_ff && !coastNow) begin
      nxt_restartZero = restartMode_ff == RESTART_FROM_ZERO;
      nxt_restartSpeed = restartMode_ff == RESTART_FROM_SPEED;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      coastPrev_ff <= 1'b0;
      restartZero_ff <= 1'b0;
      restartSpeed_ff <= 1'b0;
    end else begin
      coastPrev_ff <= nxt_coastPrev;
      restartZero_ff <= nxt_restartZero;
      restartSpeed_ff <= nxt_restartSpeed;
    end
  end

  // ************************************************************
  // Avalon slave handshake
  // ************************************************************
  // One wait state: a request is taken on one edge and completes on the next.
  always_comb begin
    acc = (avs_read || avs_write) && !ack_ff;
    wrAcc = avs_write && ack_ff;
    nxt_ack = acc;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Selectors are frozen while running so that a live command is never rerouted.
  always_comb begin
    logic locked;
    locked = cmd_ff[11];
    nxt_funcSel = funcSel_ff;
    nxt_polSel = polSel_ff;
    nxt_restartMode = restartMode_ff;
    tripClearReq = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (wrAcc && !locked && avs_address == termAddr(OFS_FUNC_BASE, i)) begin
        nxt_funcSel[i] = avs_writedata[7:0];
        if (avs_writedata[7:0] == OPT_FAULT_RESET) begin
          nxt_polSel[i] = POL_NORMALLY_OPEN;
        end
      end else if (wrAcc && !locked && avs_address == termAddr(OFS_POL_BASE, i)) begin
        if (funcSel_ff[i] != OPT_FAULT_RESET) begin
          nxt_polSel[i] = avs_writedata[7:0];
        end
      end
    end
    if (wrAcc && avs_address == OFS_CONTROL) begin
      nxt_restartMode = avs_writedata[7:0];
    end
    if (wrAcc && avs_address == OFS_TRIP) begin
      tripClearReq = avs_writedata[TRIP_CLEAR_BIT];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      funcSel_ff <= FUNC_RST;
      polSel_ff <= POL_RST;
      restartMode_ff <= RESTART_MODE_RST;
    end else begin
      funcSel_ff <= nxt_funcSel;
      polSel_ff <= nxt_polSel;
      restartMode_ff <= nxt_restartMode;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // The word is captured when a read is taken and stands until the next read.
  always_comb begin
    nxt_readData = readData_ff;
    if (acc && avs_read) begin
      nxt_readData = '0;
      for (int i = 0; i < NUM_TERM; i++) begin
        if (avs_address == termAddr(OFS_FUNC_BASE, i)) begin
          nxt_readData[7:0] = funcSel_ff[i];
        end else if (avs_address == termAddr(OFS_POL_BASE, i)) begin
          nxt_readData[7:0] = polSel_ff[i];
        end
      end
      if (avs_address == OFS_STATUS) begin
        nxt_readData[ST_RAW_LSB +: 5] = sync2_ff;
        nxt_readData[ST_ACTIVE_LSB +: 5] = active;
        nxt_readData[ST_RUN_BIT] = cmd_ff[11];
        nxt_readData[ST_SPEED_LSB +: 4] = cmd_ff[5:2];
      end else if (avs_address == OFS_CONTROL) begin
        nxt_readData[7:0] = restartMode_ff;
      end else if (avs_address == OFS_TRIP) begin
        nxt_readData[TRIP_LATCH_BIT] = trip_ff;
        nxt_readData[TRIP_CODE_LSB +: 8] = tripCode_ff;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      readData_ff <= '0;
    end else begin
      readData_ff <= nxt_readData;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign avs_readdata = readData_ff;
  assign runForwardCmd = cmd_ff[0];
  assign runReverseCmd = cmd_ff[1];
  assign speedCode = cmd_ff[5:2];
  assign jogCmd = cmd_ff[6];
  assign extDcBrakeCmd = cmd_ff[7];
  assign secondMotorSelect = cmd_ff[8];
  assign secondRampSelect = cmd_ff[9];
  assign coastStopCmd = cmd_ff[10];
  assign runMode = cmd_ff[11];
  assign faultResetCmd = cmd_ff[12];
  assign powerupResetReq = cmd_ff[12];
  assign thermistorProtectInput = cmd_ff[13];
  assign motorOutputOff = cmd_ff[14];
  assign tripLatched = trip_ff;
  assign tripErrorCode = tripCode_ff;
  assign restartFromZero = restartZero_ff;
  assign restartFromSpeed = restartSpeed_ff;

endmodule : itfm_top

//--- verif/itfm_checker_props.sv
`timescale 1ns/1ps
module itfm_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic runForwardCmd,
  input wire logic runReverseCmd,
  input wire logic jogCmd,
  input wire logic coastStopCmd,
  input wire logic runMode,
  input wire logic tripLatched,
  input wire logic [7:0] tripErrorCode,
  input wire logic faultResetCmd,
  input wire logic motorOutputOff,
  input wire logic powerupResetReq,
  input wire logic restartFromZero,
  input wire logic restartFromSpeed
);
  import itfm_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_powerup_follows_reset: assert property (powerupResetReq == faultResetCmd)
    else $error("power-up reset request differs from fault reset");
  a_run_mode_or: assert property (runMode == (runForwardCmd | runReverseCmd | jogCmd))
    else $error("run mode does not match run commands");
  a_trip_code_tied: assert property (tripErrorCode == (tripLatched ? TRIP_CODE_EXTERNAL : 8'h00))
    else $error("trip code does not match trip state");
  a_motor_off_cause: assert property (coastStopCmd || faultResetCmd || tripLatched |-> motorOutputOff)
    else $error("motor output left on");
  a_trip_holds: assert property (tripLatched
    && !(avs_write && !avs_waitrequest && avs_address == OFS_TRIP) |=> tripLatched || faultResetCmd)
    else $error("trip cleared without a reset");
  a_restart_on_fall: assert property (restartFromZero || restartFromSpeed |-> $fell(coastStopCmd))
    else $error("restart pulse without coast cancel");
  a_restart_single: assert property (restartFromZero || restartFromSpeed |->
    !(restartFromZero && restartFromSpeed) ##1 !restartFromZero && !restartFromSpeed)
    else $error("restart pulse malformed");
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait request while idle");

  c_trip_set: cover property ($rose(tripLatched));
  c_restart_speed: cover property (restartFromSpeed);
  c_run_start: cover property ($rose(runMode));
endmodule : itfm_checker

//--- verif/itfm_switch_model.sv
`timescale 1ns/1ps
module itfm_switch_model (
  input wire logic mclk,
  input wire logic [4:0] levelReq,
  input wire logic slowMode,
  output logic [4:0] terminalPin
);
  logic [4:0] lag_ff = 5'h00;
  initial terminalPin = 5'h00;
  // A slow contact settles one clock later than a fast controller output.
  always @(posedge mclk) begin
    lag_ff <= levelReq;
    terminalPin <= slowMode ? lag_ff : levelReq;
  end
endmodule : itfm_switch_model

//--- verif/input_terminal_function_map_tb.sv
`timescale 1ns/1ps
module input_terminal_function_map_tb;
  import itfm_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] terminalPin;
  logic [4:0] levelReq = 5'h00;
  logic slowMode = 1'b0;
  logic sampleReq = 1'b0;
  logic tripExp = 1'b0;
  logic runForwardCmd, runReverseCmd, jogCmd, extDcBrakeCmd, secondMotorSelect, secondRampSelect;
  logic coastStopCmd, runMode, tripLatched, faultResetCmd, motorOutputOff, powerupResetReq;
  logic thermistorProtectInput, restartFromZero, restartFromSpeed;
  logic [3:0] speedCode;
  logic [7:0] tripErrorCode;
  logic [31:0] readQ[$];
  logic [31:0] outQ[$];
  logic [7:0] fn [5];
  logic [7:0] pl [5];
  logic [7:0] codes [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0b,
    8'h12, 8'h0d, 8'h10};
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int zeroPulses = 0;
  int speedPulses = 0;
  int seed = 43;
  wire [23:0] outVec = {runForwardCmd, runReverseCmd, speedCode, jogCmd, extDcBrakeCmd, secondMotorSelect,
    secondRampSelect, coastStopCmd, faultResetCmd, thermistorProtectInput, tripLatched, runMode, motorOutputOff,
    tripErrorCode};

  always #20 mclk = ~mclk;

  itfm_top dut (.mclk, .resetn, .terminalPin, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .runForwardCmd, .runReverseCmd, .speedCode, .jogCmd, .extDcBrakeCmd,
    .secondMotorSelect, .secondRampSelect, .coastStopCmd, .runMode, .tripLatched, .tripErrorCode,
    .faultResetCmd, .motorOutputOff, .powerupResetReq, .thermistorProtectInput, .restartFromZero,
    .restartFromSpeed);
  itfm_switch_model u_switches (.mclk, .levelReq, .slowMode, .terminalPin);

  // ************************************************************
  // Checking, bus cycles and terminal stimulus
  // ************************************************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  always @(posedge mclk) begin
    cycles++;
    if (restartFromZero === 1'b1) zeroPulses++;
    if (restartFromSpeed === 1'b1) speedPulses++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(avs_readdata, readQ.pop_front());
    if (sampleReq) check({8'h0, outVec}, outQ.pop_front());
    if (cycles == 40000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    readQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic pins(input logic [4:0] v);
    @(posedge mclk);
    levelReq <= v;
    slowMode <= 1'($random(seed));
    repeat (6) @(posedge mclk);
  endtask : pins

  // Predicts every routed command from the levels and the bench's copy of the selectors.
  task automatic settle_check(input logic [4:0] p);
    logic [4:0] act;
    logic [31:0] hit;
    hit = 32'h0;
    for (int i = 0; i < 5; i++) begin
      act[i] = p[i] ^ pl[i][0];
      if (act[i] && fn[i] != 8'h13) hit[fn[i][4:0]] = 1'b1;
    end
    if (fn[4] == 8'h13) act[4] = 1'b0;
    pins(p);
    outQ.push_back({8'h0, hit[0], hit[1], hit[5:2], hit[6], hit[7], hit[8], hit[9], hit[11], hit[18],
      fn[4] == 8'h13, tripExp, hit[0] | hit[1] | hit[6], hit[11] | hit[18] | tripExp,
      tripExp ? 8'h0c : 8'h00});
    @(posedge mclk);
    sampleReq <= 1'b1;
    @(posedge mclk);
    sampleReq <= 1'b0;
    rd(OFS_STATUS, {8'h00, hit[5:2], 3'h0, hit[0] | hit[1] | hit[6], 3'h0, act, 3'h0, p});
  endtask : settle_check

  function automatic logic [4:0] idle_levels();
    for (int i = 0; i < 5; i++) idle_levels[i] = pl[i][0];
  endfunction : idle_levels

  initial begin
    fn = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12};
    pl = '{default: 8'h00};
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(OFS_FUNC_BASE + 8'(4 * i), {24'h0, fn[i]});
      rd(OFS_POL_BASE + 8'(4 * i), 32'h0);
    end
    rd(OFS_CONTROL, 32'h0);
    bus(1'b1, 8'h80, 32'hff);
    rd(8'h80, 32'h0);
    settle_check(5'h00);
    bus(1'b1, OFS_POL_BASE + 8'h10, 32'h1);
    rd(OFS_POL_BASE + 8'h10, 32'h0);
    bus(1'b1, OFS_FUNC_BASE + 8'h08, 32'h0c);
    fn[2] = 8'h0c;
    tripExp = 1'b1;
    settle_check(5'h04);
    settle_check(5'h00);
    rd(OFS_TRIP, 32'h0c01);
    tripExp = 1'b0;
    settle_check(5'h10);
    tripExp = 1'b1;
    settle_check(5'h04);
    bus(1'b1, OFS_TRIP, 32'h1);
    tripExp = 1'b0;
    rd(OFS_TRIP, 32'h0);
    settle_check(5'h01);
    bus(1'b1, OFS_FUNC_BASE + 8'h08, 32'h07);
    rd(OFS_FUNC_BASE + 8'h08, 32'h0c);
    settle_check(5'h00);
    bus(1'b1, OFS_FUNC_BASE + 8'h08, 32'h0b);
    fn[2] = 8'h0b;
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, OFS_CONTROL, 32'(m));
      settle_check(5'h04);
      settle_check(5'h00);
    end
    check(32'(zeroPulses), 32'h1);
    check(32'(speedPulses), 32'h1);
    bus(1'b1, OFS_FUNC_BASE + 8'h10, 32'h13);
    bus(1'b1, OFS_FUNC_BASE, 32'h13);
    fn[4] = 8'h13;
    fn[0] = 8'h13;
    settle_check(5'h01);
    for (int r = 0; r < 10; r++) begin
      pins(idle_levels());
      for (int i = 0; i < 5; i++) bus(1'b1, OFS_FUNC_BASE + 8'(4 * i), 32'h07);
      for (int i = 0; i < 5; i++) begin
        fn[i] = codes[{$random(seed)} % 14];
        pl[i] = {7'h0, 1'($random(seed))};
        bus(1'b1, OFS_POL_BASE + 8'(4 * i), {24'h0, pl[i]});
      end
      pins(idle_levels());
      for (int i = 0; i < 5; i++) begin
        bus(1'b1, OFS_FUNC_BASE + 8'(4 * i), {24'h0, fn[i]});
        if (fn[i] == 8'h12) pl[i] = 8'h00;
        rd(OFS_POL_BASE + 8'(4 * i), {24'h0, pl[i]});
      end
      settle_check(5'($random(seed)));
    end
    report_and_stop();
  end
endmodule : input_terminal_function_map_tb

bind itfm_top itfm_checker u_chk (.mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_waitrequest,
  .runForwardCmd, .runReverseCmd, .jogCmd, .coastStopCmd, .runMode, .tripLatched, .tripErrorCode,
  .faultResetCmd, .motorOutputOff, .powerupResetReq, .restartFromZero, .restartFromSpeed);
